// ==== ultrasonic_burst_generator.sv ====
/*
  two-channel burst generator with an AXI4-Lite register slave,
  push-pull sequencer, two independent generators and port steering.
  assumes analog power is enabled by software before firing, and that
  the cpu port bits arrive synchronous to aclk.
*/
`timescale 1ns/1ns
`default_nettype none
module ultrasonic_burst_generator (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        cpu_port2_bit0,
  input  wire logic        cpu_port2_bit1,
  output logic             drive_pin_a,
  output logic             drive_pin_b
);
  // ------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------
  logic [2:0]  mode_q;
  logic [5:0]  pulse_count_a_q;
  logic [5:0]  pulse_count_b_q;
  logic [10:0] on_a_q;
  logic [10:0] off_a_q;
  logic [10:0] on_b_q;
  logic [10:0] off_b_q;
  logic [7:0]  gap_cycles_q;

  // ------------------------------------------------------------
  // write channel: address and data taken in either order
  // ------------------------------------------------------------
  logic        aw_full_q;
  logic [11:0] aw_addr_q;
  logic        w_full_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;

  wire         aw_take  = s_axi_awvalid && s_axi_awready;
  wire         w_take   = s_axi_wvalid && s_axi_wready;
  wire         wr_fire  = aw_full_q && w_full_q && !bvalid_q;
  wire  [9:0]  wr_idx   = aw_addr_q[11:2];
  wire         wr_lane0 = wr_fire && w_strb_q[0];
  wire         wr_lane1 = wr_fire && w_strb_q[1];

  wire         hit_mode   = (wr_idx == burst_pkg::IDX_MODE);
  wire         hit_fire   = (wr_idx == burst_pkg::IDX_FIRE);
  wire         hit_stat   = (wr_idx == burst_pkg::IDX_STATUS);
  wire         hit_pa     = (wr_idx == burst_pkg::IDX_PULSE_A);
  wire         hit_pb     = (wr_idx == burst_pkg::IDX_PULSE_B);
  wire         hit_ona    = (wr_idx == burst_pkg::IDX_ON_A);
  wire         hit_offa   = (wr_idx == burst_pkg::IDX_OFF_A);
  wire         hit_onb    = (wr_idx == burst_pkg::IDX_ON_B);
  wire         hit_offb   = (wr_idx == burst_pkg::IDX_OFF_B);
  wire         hit_gap    = (wr_idx == burst_pkg::IDX_GAP);
  wire         wr_mapped  = hit_mode | hit_fire | hit_stat | hit_pa
                          | hit_pb | hit_ona | hit_offa | hit_onb
                          | hit_offb | hit_gap;

  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready  = !w_full_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 12'h000;
      w_full_q  <= 1'b0;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= burst_pkg::RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_mapped ? burst_pkg::RESP_OKAY
                               : burst_pkg::RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // configuration registers, byte lanes 0 and 1
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q          <= burst_pkg::MODE_RESET;
      pulse_count_a_q <= burst_pkg::PULSE_RESET;
      pulse_count_b_q <= burst_pkg::PULSE_RESET;
      on_a_q          <= burst_pkg::TIME_RESET;
      off_a_q         <= burst_pkg::TIME_RESET;
      on_b_q          <= burst_pkg::TIME_RESET;
      off_b_q         <= burst_pkg::TIME_RESET;
      gap_cycles_q    <= burst_pkg::GAP_RESET;
    end else begin
      if (wr_lane0 && hit_mode) mode_q <= w_data_q[2:0];
      if (wr_lane0 && hit_pa) pulse_count_a_q <= w_data_q[5:0];
      if (wr_lane0 && hit_pb) pulse_count_b_q <= w_data_q[5:0];
      if (wr_lane0 && hit_ona) on_a_q[7:0] <= w_data_q[7:0];
      if (wr_lane1 && hit_ona) on_a_q[10:8] <= w_data_q[10:8];
      if (wr_lane0 && hit_offa) off_a_q[7:0] <= w_data_q[7:0];
      if (wr_lane1 && hit_offa) off_a_q[10:8] <= w_data_q[10:8];
      if (wr_lane0 && hit_onb) on_b_q[7:0] <= w_data_q[7:0];
      if (wr_lane1 && hit_onb) on_b_q[10:8] <= w_data_q[10:8];
      if (wr_lane0 && hit_offb) off_b_q[7:0] <= w_data_q[7:0];
      if (wr_lane1 && hit_offb) off_b_q[10:8] <= w_data_q[10:8];
      if (wr_lane0 && hit_gap) gap_cycles_q <= w_data_q[7:0];
    end
  end

  // fire bits act on the write itself and are never stored
  wire fire_a = wr_lane0 && hit_fire && w_data_q[burst_pkg::FIRE_A_BIT];
  wire fire_b = wr_lane0 && hit_fire && w_data_q[burst_pkg::FIRE_B_BIT];

  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------
  wire mode_pp    = (mode_q == burst_pkg::MODE_PUSHPULL);
  wire mode_ga_pb = (mode_q == burst_pkg::MODE_GENA_PORTB);
  wire mode_pa_gb = (mode_q == burst_pkg::MODE_PORTA_GENB);
  wire mode_indep = (mode_q == burst_pkg::MODE_INDEP);
  wire mode_ports = (mode_q == burst_pkg::MODE_PORTS);
  wire gen_a_used = mode_ga_pb | mode_indep;
  wire gen_b_used = mode_pa_gb | mode_indep;

  // ------------------------------------------------------------
  // 16 MHz tick: 16 of every 50 aclk cycles, evenly spread
  // ------------------------------------------------------------
  logic [6:0] acc_q;
  logic       tick_q;
  wire  [6:0] acc_sum  = acc_q + burst_pkg::TICK_STEP;
  wire        acc_wrap = (acc_sum >= burst_pkg::TICK_WRAP);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_q  <= 7'h00;
      tick_q <= 1'b0;
    end else begin
      acc_q  <= acc_wrap ? (acc_sum - burst_pkg::TICK_WRAP) : acc_sum;
      tick_q <= acc_wrap;
    end
  end

  // ------------------------------------------------------------
  // independent generators
  // ------------------------------------------------------------
  logic gen_a_out;
  logic gen_a_busy;
  logic gen_b_out;
  logic gen_b_busy;

  pulse_train gen_a (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .tick      (tick_q),
    .start     (fire_a && gen_a_used),
    .pulses    (pulse_count_a_q),
    .on_len    (on_a_q),
    .off_len   (off_a_q),
    .pulse_out (gen_a_out),
    .busy      (gen_a_busy)
  );

  pulse_train gen_b (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .tick      (tick_q),
    .start     (fire_b && gen_b_used),
    .pulses    (pulse_count_b_q),
    .on_len    (on_b_q),
    .off_len   (off_b_q),
    .pulse_out (gen_b_out),
    .busy      (gen_b_busy)
  );

  // ------------------------------------------------------------
  // push-pull sequencer: A on, gap, B on, gap, repeat
  // ------------------------------------------------------------
  burst_pkg::pp_state_t pp_q;
  burst_pkg::pp_state_t pp_d;
  logic [5:0]  left_a_q;
  logic [5:0]  left_a_d;
  logic [5:0]  left_b_q;
  logic [5:0]  left_b_d;
  logic [10:0] pcnt_q;
  logic [10:0] pcnt_d;
  wire  [10:0] pcnt_inc = pcnt_q + 11'h001;
  // channel B conducts for the A off time
  wire         on_end   = tick_q && !(&pcnt_q) && (pcnt_inc >= on_a_q);
  wire         off_end  = tick_q && (pcnt_inc >= off_a_q);
  wire         gap_end  = tick_q && (pcnt_inc >= {3'h0, gap_cycles_q});
  wire         pp_more  = (left_a_q != 6'h00) || (left_b_q != 6'h00);

  always_comb begin
    pp_d     = pp_q;
    left_a_d = left_a_q;
    left_b_d = left_b_q;
    pcnt_d   = tick_q ? pcnt_inc : pcnt_q;
    unique case (pp_q)
      burst_pkg::PP_IDLE: begin
        pcnt_d = fire_a ? 11'h7FF : 11'h000;
        // one fire bit starts both channels
        if (fire_a && mode_pp &&
            ((pulse_count_a_q != 6'h00) || (pulse_count_b_q != 6'h00))) begin
          pp_d     = burst_pkg::PP_A_ON;
          left_a_d = pulse_count_a_q;
          left_b_d = pulse_count_b_q;
        end
      end
      burst_pkg::PP_A_ON: begin
        if (on_end) begin
          pp_d   = burst_pkg::PP_GAP1;
          pcnt_d = 11'h000;
          if (left_a_q != 6'h00) left_a_d = left_a_q - 6'h01;
        end
      end
      burst_pkg::PP_GAP1: begin
        if (gap_end) begin
          pp_d   = burst_pkg::PP_B_ON;
          pcnt_d = 11'h000;
        end
      end
      burst_pkg::PP_B_ON: begin
        if (off_end) begin
          pp_d   = burst_pkg::PP_GAP2;
          pcnt_d = 11'h000;
          if (left_b_q != 6'h00) left_b_d = left_b_q - 6'h01;
        end
      end
      burst_pkg::PP_GAP2: begin
        if (gap_end) begin
          pcnt_d = 11'h000;
          pp_d   = pp_more ? burst_pkg::PP_A_ON : burst_pkg::PP_IDLE;
        end
      end
      default: begin
        pp_d = burst_pkg::PP_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pp_q     <= burst_pkg::PP_IDLE;
      left_a_q <= 6'h00;
      left_b_q <= 6'h00;
      pcnt_q   <= 11'h000;
    end else begin
      pp_q     <= pp_d;
      left_a_q <= left_a_d;
      left_b_q <= left_b_d;
      pcnt_q   <= pcnt_d;
    end
  end

  wire pp_a = (pp_q == burst_pkg::PP_A_ON) && (left_a_q != 6'h00);
  wire pp_b = (pp_q == burst_pkg::PP_B_ON) && (left_b_q != 6'h00);

  // ------------------------------------------------------------
  // pin steering; reserved codes keep both FETs off
  // ------------------------------------------------------------
  // port bit 0 to pin A
  wire port_a_used = mode_pa_gb | mode_ports;
  // port bit 1 to pin B
  wire port_b_used = mode_ga_pb | mode_ports;
  wire pin_a_d = (mode_pp && pp_a) | (gen_a_used && gen_a_out)
               | (port_a_used && cpu_port2_bit0);
  wire pin_b_d = (mode_pp && pp_b) | (gen_b_used && gen_b_out)
               | (port_b_used && cpu_port2_bit1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_pin_a <= 1'b0;
      drive_pin_b <= 1'b0;
    end else begin
      drive_pin_a <= pin_a_d;
      drive_pin_b <= pin_b_d;
    end
  end

  // ------------------------------------------------------------
  // read channel, one cycle after the address is taken
  // ------------------------------------------------------------
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  wire  [9:0]  rd_idx  = s_axi_araddr[11:2];
  wire         ar_take = s_axi_arvalid && s_axi_arready;
  wire         pp_busy = (pp_q != burst_pkg::PP_IDLE);
  wire  [1:0]  busy_bits = {gen_b_busy | pp_busy, gen_a_busy | pp_busy};
  logic [31:0] rd_word;
  logic        rd_hit;

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_comb begin
    rd_word = 32'h00000000;
    rd_hit  = 1'b1;
    unique case (rd_idx)
      burst_pkg::IDX_MODE:    rd_word[2:0]  = mode_q;
      burst_pkg::IDX_FIRE:    rd_word       = 32'h00000000;
      burst_pkg::IDX_STATUS:  rd_word[1:0]  = busy_bits;
      burst_pkg::IDX_PULSE_A: rd_word[5:0]  = pulse_count_a_q;
      burst_pkg::IDX_PULSE_B: rd_word[5:0]  = pulse_count_b_q;
      burst_pkg::IDX_ON_A:    rd_word[10:0] = on_a_q;
      burst_pkg::IDX_OFF_A:   rd_word[10:0] = off_a_q;
      burst_pkg::IDX_ON_B:    rd_word[10:0] = on_b_q;
      burst_pkg::IDX_OFF_B:   rd_word[10:0] = off_b_q;
      burst_pkg::IDX_GAP:     rd_word[7:0]  = gap_cycles_q;
      default:                rd_hit        = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= burst_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= rd_hit ? burst_pkg::RESP_OKAY : burst_pkg::RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
endmodule : ultrasonic_burst_generator
`default_nettype wire

// ==== burst_pkg.sv ====
/*
  constants, register map and state codes shared by the burst generator
  files. assumes a 50 MHz aclk and an AXI4-Lite register bus.
*/
// Overview of operation
// - 3-bit drive mode at index 0xB3, reset zero, selects both channels.
// - mode 000 runs channels A and B as a push-pull pair.
// - push-pull burst on both channels starts on the channel A fire bit.
// - push-pull channel B timed from A on, A off and gap settings.
// - generator A emits pulse_count_a pulses, 0 to 63.
// - generator B emits pulse_count_b pulses, 0 to 63.
// - channel A high time is an 11-bit count of 16 MHz ticks.
// - channel A low time is an 11-bit count of 16 MHz ticks.
// - push-pull spacing uses an 8-bit gap count of 16 MHz ticks.
// - mode 001: generator A on pin A, pin B follows port bit 1.
// - mode 010: pin A follows port bit 0, generator B on pin B.
// - independent generator B uses its own 11-bit on and off times.
// - mode 011: both generators independent, each with own fire bit.
// - mode 100: pins A and B follow port bits 0 and 1.
// - port modes steer pin A from port bit 0, pin B from bit 1.
`default_nettype none
package burst_pkg;
  // ------------------------------------------------------------
  // register indices, byte address is four times the index
  // ------------------------------------------------------------
  localparam logic [9:0] IDX_MODE      = 10'h0B3;
  localparam logic [9:0] IDX_FIRE      = 10'h0B4;
  localparam logic [9:0] IDX_STATUS    = 10'h0B5;
  localparam logic [9:0] IDX_PULSE_A   = 10'h0B6;
  localparam logic [9:0] IDX_PULSE_B   = 10'h0B7;
  localparam logic [9:0] IDX_ON_A      = 10'h0B8;
  localparam logic [9:0] IDX_OFF_A     = 10'h0B9;
  localparam logic [9:0] IDX_ON_B      = 10'h0BA;
  localparam logic [9:0] IDX_OFF_B     = 10'h0BB;
  localparam logic [9:0] IDX_GAP       = 10'h0BC;
  // ------------------------------------------------------------
  // fields and reset values
  // ------------------------------------------------------------
  localparam int         FIRE_A_BIT    = 0;
  localparam int         FIRE_B_BIT    = 1;
  localparam int         BUSY_A_BIT    = 0;
  localparam int         BUSY_B_BIT    = 1;
  localparam logic [2:0] MODE_RESET    = 3'h0;
  localparam logic [5:0] PULSE_RESET   = 6'h00;
  localparam logic [10:0] TIME_RESET   = 11'h000;
  localparam logic [7:0] GAP_RESET     = 8'h00;
  // ------------------------------------------------------------
  // drive modes
  // ------------------------------------------------------------
  localparam logic [2:0] MODE_PUSHPULL = 3'h0;
  localparam logic [2:0] MODE_GENA_PORTB = 3'h1;
  localparam logic [2:0] MODE_PORTA_GENB = 3'h2;
  localparam logic [2:0] MODE_INDEP    = 3'h3;
  localparam logic [2:0] MODE_PORTS    = 3'h4;
  // ------------------------------------------------------------
  // 16 MHz tick from 50 MHz by fractional accumulation
  // ------------------------------------------------------------
  localparam logic [6:0] TICK_STEP     = 7'h10;
  localparam logic [6:0] TICK_WRAP     = 7'h32;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;
  // ------------------------------------------------------------
  // state codes
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    GEN_IDLE = 3'b001,
    GEN_HIGH = 3'b010,
    GEN_LOW  = 3'b100
  } gen_state_t;
  typedef enum logic [4:0] {
    PP_IDLE = 5'b00001,
    PP_A_ON = 5'b00010,
    PP_GAP1 = 5'b00100,
    PP_B_ON = 5'b01000,
    PP_GAP2 = 5'b10000
  } pp_state_t;
endpackage : burst_pkg
`default_nettype wire

// ==== pulse_train.sv ====
/*
  one independent pulse generator: a train of high and low phases
  counted on the 16 MHz tick enable.
  assumes start is a one-cycle pulse and settings are stable while busy.
*/
`timescale 1ns/1ns
`default_nettype none
module pulse_train (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        tick,
  input  wire logic        start,
  input  wire logic [5:0]  pulses,
  input  wire logic [10:0] on_len,
  input  wire logic [10:0] off_len,
  output logic             pulse_out,
  output logic             busy
);
  burst_pkg::gen_state_t state_q;
  burst_pkg::gen_state_t state_d;
  logic [5:0]            left_q;
  logic [5:0]            left_d;
  logic [10:0]           cnt_q;
  logic [10:0]           cnt_d;
  wire  [10:0]           cnt_inc = cnt_q + 11'h001;
  // a zero length still lasts one tick; all ones marks the partial tick
  // before the first high phase, so no pulse comes out shorter than set
  wire                   high_end = tick && !(&cnt_q) && (cnt_inc >= on_len);
  wire                   low_end  = tick && (cnt_inc >= off_len);

  always_comb begin
    state_d = state_q;
    left_d  = left_q;
    cnt_d   = tick ? cnt_inc : cnt_q;
    unique case (state_q)
      burst_pkg::GEN_IDLE: begin
        cnt_d = start ? 11'h7FF : 11'h000;
        if (start && (pulses != 6'h00)) begin
          state_d = burst_pkg::GEN_HIGH;
          left_d  = pulses;
        end
      end
      burst_pkg::GEN_HIGH: begin
        if (high_end) begin
          state_d = burst_pkg::GEN_LOW;
          cnt_d   = 11'h000;
          left_d  = left_q - 6'h01;
        end
      end
      burst_pkg::GEN_LOW: begin
        if (low_end) begin
          cnt_d   = 11'h000;
          state_d = (left_q == 6'h00) ? burst_pkg::GEN_IDLE
                                      : burst_pkg::GEN_HIGH;
        end
      end
      default: begin
        state_d = burst_pkg::GEN_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q   <= burst_pkg::GEN_IDLE;
      left_q    <= 6'h00;
      cnt_q     <= 11'h000;
      pulse_out <= 1'b0;
    end else begin
      state_q   <= state_d;
      left_q    <= left_d;
      cnt_q     <= cnt_d;
      pulse_out <= (state_d == burst_pkg::GEN_HIGH);
    end
  end

  assign busy = (state_q != burst_pkg::GEN_IDLE);
endmodule : pulse_train
`default_nettype wire

// ==== ultrasonic_burst_generator_monitor.sv ====
/* port checker for the burst generator
   assumes it is bound to ultrasonic_burst_generator */
`timescale 1ns/1ns
`default_nettype none
module burst_port_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        cpu_port2_bit0,
  input wire logic        cpu_port2_bit1,
  input wire logic        drive_pin_a,
  input wire logic        drive_pin_b
);
  // mode copy lands one edge after the take, as the register does
  logic        wr_q;
  logic [11:0] wa_q;
  logic [2:0]  wd_q;
  logic [2:0]  mode_q;
  wire         take;
  assign take = s_axi_awvalid && s_axi_awready && s_axi_wvalid
                && s_axi_wready;
  always_ff @(posedge aclk) begin
    wr_q <= take && aresetn;
    wa_q <= s_axi_awaddr;
    wd_q <= s_axi_wdata[2:0];
    if (!aresetn) mode_q <= 3'h0;
    else if (wr_q && wa_q == {burst_pkg::IDX_MODE, 2'h0}) mode_q <= wd_q;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence gap_low;
    !drive_pin_b [*3];
  endsequence
  chk_write_resp: assert property (
    take |-> ##2 s_axi_bvalid) else $error("write answer late");
  chk_read_resp: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_ar_block: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  chk_b_drop: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer stuck");
  chk_pp_overlap: assert property (
    mode_q == 3'h0 |-> !(drive_pin_a && drive_pin_b))
    else $error("both pins on in push-pull");
  chk_pp_gap: assert property (
    mode_q == 3'h0 && $fell(drive_pin_a) |-> gap_low)
    else $error("no gap after pin a");
  chk_on_min: assert property (
    $rose(drive_pin_a) && mode_q != 3'h2 && mode_q != 3'h4
    |-> drive_pin_a [*3]) else $error("pin a pulse too short");
  chk_port_a: assert property (
    mode_q == 3'h2 || mode_q == 3'h4
    |=> drive_pin_a == $past(cpu_port2_bit0)) else $error("pin a off port");
  chk_port_b: assert property (
    mode_q == 3'h1 || mode_q == 3'h4
    |=> drive_pin_b == $past(cpu_port2_bit1)) else $error("pin b off port");
endmodule : burst_port_monitor
bind ultrasonic_burst_generator burst_port_monitor mon (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .cpu_port2_bit0, .cpu_port2_bit1, .drive_pin_a, .drive_pin_b);
`default_nettype wire

// ==== fet_load_model.sv ====
/* the two low-side fets seen as turn-on counters
   assumes gate levels settle before each aclk edge */
`timescale 1ns/1ns
`default_nettype none
module fet_load_model (
  input wire logic aclk,
  input wire logic gate_a,
  input wire logic gate_b,
  output int       rises_a,
  output int       rises_b
);
  logic a_q;
  logic b_q;
  initial begin
    a_q = 1'b0;
    b_q = 1'b0;
    rises_a = 0;
    rises_b = 0;
  end
  // each turn-on is one current pulse into a primary coil
  always @(posedge aclk) begin
    a_q <= gate_a;
    b_q <= gate_b;
    if (gate_a && !a_q) rises_a <= rises_a + 1;
    if (gate_b && !b_q) rises_b <= rises_b + 1;
  end
endmodule : fet_load_model
`default_nettype wire

// ==== tb_ultrasonic_burst_generator.sv ====
/* self-checking bench for the burst generator
   assumes burst_pkg, the design, its monitor and the fet model */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  failures++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb_ultrasonic_burst_generator;
  localparam logic [1:0] OK = burst_pkg::RESP_OKAY;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, cpu_port2_bit0, cpu_port2_bit1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, drive_pin_a, drive_pin_b;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, v;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          failures, check_count, rises_a, rises_b;
  ultrasonic_burst_generator dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cpu_port2_bit0, .cpu_port2_bit1,
    .drive_pin_a, .drive_pin_b);
  fet_load_model load (.aclk, .gate_a(drive_pin_a), .gate_b(drive_pin_b),
    .rises_a, .rises_b);
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize
  task automatic tmo;
    failures++;
    summarize();
  endtask : tmo
  task automatic wr(input logic [9:0] i, input logic [31:0] x,
                    input logic [1:0] e);
    int n;
    @(posedge aclk);
    n = 0;
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= x;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    `CHK("bresp", e, s_axi_bresp)
    if (n >= 50) tmo();
  endtask : wr
  task automatic rd(input logic [9:0] i, input logic [1:0] e,
                    output logic [31:0] x);
    int n;
    @(posedge aclk);
    n = 0;
    s_axi_araddr <= {i, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'b0;
    x = s_axi_rdata;
    `CHK("rresp", e, s_axi_rresp)
    if (n >= 50) tmo();
  endtask : rd
  function automatic int fmask(int i);
    case (i)
      32'hB3: return 32'h7;
      32'hB6, 32'hB7: return 32'h3F;
      32'hBC: return 32'hFF;
      32'hB8, 32'hB9, 32'hBA, 32'hBB: return 32'h7FF;
      default: return 32'h0;
    endcase
  endfunction : fmask
  task automatic burst(input logic [2:0] m, input int pa, input int pb,
                       input logic [1:0] f);
    int a0, b0, ea, eb, n;
    logic [31:0] x;
    wr(burst_pkg::IDX_MODE, {29'h0, m}, OK);
    wr(burst_pkg::IDX_PULSE_A, pa, OK);
    wr(burst_pkg::IDX_PULSE_B, pb, OK);
    for (int i = 32'hB8; i <= 32'hBC; i++) wr(i[9:0], $urandom_range(3), OK);
    a0 = rises_a;
    b0 = rises_b;
    wr(burst_pkg::IDX_FIRE, {30'h0, f}, OK);
    n = 0;
    do begin
      rd(burst_pkg::IDX_STATUS, OK, x);
      n++;
    end while (x !== 32'h0 && n < 2000);
    if (n >= 2000) tmo();
    // which fire bit starts which generator
    ea = (m != 3'h2 && f[0]) ? pa : 0;
    eb = (m == 3'h0 ? f[0] : m[1] && f[1]) ? pb : 0;
    repeat (3) @(posedge aclk);
    `CHK("pulses_a", ea, rises_a - a0)
    `CHK("pulses_b", eb, rises_b - b0)
  endtask : burst
  task automatic ports(input logic [2:0] m);
    wr(burst_pkg::IDX_MODE, {29'h0, m}, OK);
    repeat (16) begin
      cpu_port2_bit0 <= $urandom;
      cpu_port2_bit1 <= $urandom;
      @(posedge aclk);
      @(posedge aclk);
      `CHK("pin_a", (m[1] | m[2]) & cpu_port2_bit0, drive_pin_a)
      `CHK("pin_b", (m[0] | m[2]) & cpu_port2_bit1, drive_pin_b)
    end
    cpu_port2_bit0 <= 1'b0;
    cpu_port2_bit1 <= 1'b0;
  endtask : ports
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, cpu_port2_bit0, cpu_port2_bit1} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    failures = 0;
    check_count = 0;
    void'($urandom(1403));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 32'hB3; i <= 32'hBC; i++) begin
      rd(i[9:0], OK, d);
      `CHK("reset", 32'h0, d)
      if (i != 32'hB4 && i != 32'hB5) begin
        v = (i == 32'hB3) ? $urandom_range(4) : $urandom;
        wr(i[9:0], v, OK);
        rd(i[9:0], OK, d);
        `CHK("reg", v & fmask(i), d)
      end
    end
    rd(10'h0A0, burst_pkg::RESP_SLVERR, d);
    `CHK("unmapped", 32'h0, d)
    wr(10'h0A0, 32'hFFFF, burst_pkg::RESP_SLVERR);
    burst(3'h0, 1 + $urandom_range(7), 1 + $urandom_range(7), 2'h1);
    burst(3'h0, 2, 3, 2'h2);
    burst(3'h3, 63, 0, 2'h3);
    ports(3'h1);
    burst(3'h1, 4, 9, 2'h1);
    ports(3'h2);
    burst(3'h2, 9, 5, 2'h2);
    ports(3'h4);
    summarize();
  end
endmodule : tb_ultrasonic_burst_generator
`default_nettype wire
